// *** design/ccp_defines.svh ***
`ifndef CCP_DEFINES_SVH
`define CCP_DEFINES_SVH

// Two-wire slave address and general-call address
`define CCP_I2C_ADDR 7'h18
`define CCP_GC_BYTE 8'h00

// Bit counts inside a two-wire byte (data bits, then acknowledge)
`define CCP_BYTE_BITS 4'h8
`define CCP_ACK_BIT 4'h9

// Falling-edge counts inside a four-wire frame
`define CCP_SPI_CMD_LAST 5'h07
`define CCP_SPI_CMD_DONE 5'h08
`define CCP_SPI_DATA_LAST 5'h0f
`define CCP_SPI_FRAME_DONE 5'h10

// Reset values
`define CCP_RST_BYTE 8'h00
`define CCP_RST_PTR 7'h00

// Idle level of the two-wire lines, held by the pull-ups
`define CCP_RST_LINE 1'b1

`endif

// *** design/ccp_pkg.sv ***
package ccp_pkg;

	// Two-wire transfer phases
	typedef enum logic [2:0] {
		I2C_IDLE,
		I2C_ADDR,
		I2C_PTR,
		I2C_WDATA,
		I2C_RDATA,
		I2C_SKIP
	} ccp_i2c_st_e;

	// State of the system-clock side
	typedef struct packed {
		ccp_i2c_st_e st;
		logic [3:0] bitCnt;
		logic [7:0] shReg;
		logic [6:0] ptr;
		logic rdWr;
		logic acked;
		logic sdaLow;
		logic sclS1;
		logic sclS2;
		logic sclP;
		logic sdaS1;
		logic sdaS2;
		logic sdaP;
		logic strapS1;
		logic strapS2;
		logic togS1;
		logic togS2;
		logic togS3;
		logic wrEn;
		logic [6:0] wrAddr;
		logic [7:0] wrData;
	} ccp_core_s;

	// State of the four-wire frame, sampled on falling serial clock
	typedef struct packed {
		logic [4:0] fallCnt;
		logic [7:0] shIn;
		logic [7:0] cmd;
	} ccp_spi_s;

	// Write hand-off from the serial clock domain
	typedef struct packed {
		logic tog;
		logic [6:0] addr;
		logic [7:0] data;
	} ccp_spiw_s;

endpackage

// *** design/ccp_control_port.sv ***
`timescale 1ns/100ps
`include "ccp_defines.svh"

module ccp_control_port
	import ccp_pkg::*;
(
	// System clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Strap and configuration
	input wire logic spiSelect,
	input wire logic gcEnable,
	// Two-wire bus
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// Four-wire port
	input wire logic spiSclk,
	input wire logic portSelectN,
	input wire logic mosi,
	output logic misoOut,
	output logic misoOe,
	// Register file access
	output logic [6:0] regRdAddr,
	input wire logic [7:0] regRdData,
	output logic regWrEn,
	output logic [6:0] regWrAddr,
	output logic [7:0] regWrData
);

	// Line synchronisers start at the idle-high level of the pins, so the
	// release of reset shows no false edge, start or stop on the bus
	localparam ccp_core_s CORE_RST = '{
		st: I2C_IDLE,
		shReg: `CCP_RST_BYTE,
		ptr: `CCP_RST_PTR,
		sclS1: `CCP_RST_LINE,
		sclS2: `CCP_RST_LINE,
		sclP: `CCP_RST_LINE,
		sdaS1: `CCP_RST_LINE,
		sdaS2: `CCP_RST_LINE,
		sdaP: `CCP_RST_LINE,
		wrAddr: `CCP_RST_PTR,
		wrData: `CCP_RST_BYTE,
		default: '0
	};

	ccp_core_s q;
	ccp_core_s d;
	ccp_spi_s spiQ;
	ccp_spi_s spiD;
	ccp_spiw_s swQ;
	ccp_spiw_s swD;
	logic misoBitQ;
	logic misoOeQ;
	logic spiRstN;
	logic spiMode;
	logic sclRise;
	logic sclFall;
	logic startSeen;
	logic stopSeen;
	logic addrMatch;
	logic [7:0] spiByte;

	// Four-wire frame state lives only while the select is low
	assign spiRstN = rst_n & ~portSelectN;

	assign spiMode = q.strapS2;

	// Edges of the synchronised two-wire lines
	assign sclRise = q.sclS2 & ~q.sclP;
	assign sclFall = ~q.sclS2 & q.sclP;

	assign startSeen = q.sclS2 & q.sclP & q.sdaP & ~q.sdaS2;
	assign stopSeen = q.sclS2 & q.sclP & ~q.sdaP & q.sdaS2;

	assign addrMatch = (q.shReg[7:1] == `CCP_I2C_ADDR) |
		(gcEnable & (q.shReg == `CCP_GC_BYTE));

	// Byte completed by the current falling edge
	assign spiByte = {spiQ.shIn[6:0], mosi};

	always_comb begin
		spiD = spiQ;
		spiD.shIn = spiByte;
		if (spiQ.fallCnt != `CCP_SPI_FRAME_DONE) begin
			spiD.fallCnt = spiQ.fallCnt + 5'h01;
		end
		if (spiQ.fallCnt == `CCP_SPI_CMD_LAST) begin
			spiD.cmd = spiByte;
		end
	end

	// Reset by select high, so each frame starts at bit zero
	// fresh select edge
	always_ff @(negedge spiSclk or negedge spiRstN) begin
		if (!spiRstN) begin
			spiQ <= '0;
		end else begin
			spiQ <= spiD;
		end
	end

	// Write hand-off; kept over select so the other side can copy it
	always_comb begin
		swD = swQ;
		if (spiQ.fallCnt == `CCP_SPI_DATA_LAST && !spiQ.cmd[0]) begin
			swD.addr = spiQ.cmd[7:1];
			swD.data = spiByte;
			swD.tog = ~swQ.tog;
		end
	end

	always_ff @(negedge spiSclk or negedge rst_n) begin
		if (!rst_n) begin
			swQ <= '0;
		end else begin
			swQ <= swD;
		end
	end

	// Slave-out changes on the rising edge so it is stable at sampling.
	// The read byte is fetched half a clock after the command ends,
	// too soon for a crossing; the register file must hold still.
	// read data phase
	always_ff @(posedge spiSclk or negedge spiRstN) begin
		if (!spiRstN) begin
			misoBitQ <= 1'b0;
			misoOeQ <= 1'b0;
		end else begin
			misoOeQ <= spiQ.cmd[0] &
				(spiQ.fallCnt >= `CCP_SPI_CMD_DONE) &
				(spiQ.fallCnt < `CCP_SPI_FRAME_DONE);
			misoBitQ <= regRdData[~spiQ.fallCnt[2:0]];
		end
	end

	// System-clock side: synchronisers, two-wire engine, write port
	always_comb begin
		d = q;
		d.wrEn = 1'b0;
		d.strapS1 = spiSelect;
		d.strapS2 = q.strapS1;
		d.sclS1 = sclIn;
		d.sclS2 = q.sclS1;
		d.sclP = q.sclS2;
		d.sdaS1 = sdaIn;
		d.sdaS2 = q.sdaS1;
		d.sdaP = q.sdaS2;
		d.togS1 = swQ.tog;
		d.togS2 = q.togS1;
		d.togS3 = q.togS2;
		if (spiMode) begin
			// Two-wire engine held idle in four-wire mode
			d.st = I2C_IDLE;
			d.sdaLow = 1'b0;
			// Toggle edge means hand-off words are settled
			if (q.togS2 != q.togS3) begin
				d.wrEn = 1'b1;
				d.wrAddr = swQ.addr;
				d.wrData = swQ.data;
			end
		end else if (startSeen) begin
			d.st = I2C_ADDR;
			d.bitCnt = 4'h0;
			d.sdaLow = 1'b0;
		end else if (stopSeen) begin
			d.st = I2C_IDLE;
			d.sdaLow = 1'b0;
		end else if (q.st != I2C_IDLE && q.st != I2C_SKIP) begin
			if (sclRise) begin
				d.bitCnt = q.bitCnt + 4'h1;
				if (q.bitCnt == `CCP_BYTE_BITS) begin
					if (q.st == I2C_RDATA) begin
						d.acked = ~q.sdaS2;
						if (!q.sdaS2) begin
							d.ptr = q.ptr + 7'h01;
						end
					end
				end else if (q.st != I2C_RDATA) begin
					d.shReg = {q.shReg[6:0], q.sdaS2};
				end
			end
			if (sclFall) begin
				if (q.bitCnt == `CCP_BYTE_BITS) begin
					unique case (q.st)
						I2C_ADDR: begin
							if (addrMatch) begin
								d.sdaLow = 1'b1;
								d.rdWr = q.shReg[0];
							end else begin
								d.st = I2C_SKIP;
							end
						end
						I2C_PTR: begin
							d.ptr = q.shReg[6:0];
							d.sdaLow = 1'b1;
						end
						I2C_WDATA: begin
							d.wrEn = 1'b1;
							d.wrAddr = q.ptr;
							d.wrData = q.shReg;
							d.sdaLow = 1'b1;
						end
						I2C_RDATA: d.sdaLow = 1'b0;
						I2C_IDLE, I2C_SKIP: d.sdaLow = 1'b0;
					endcase
				end else if (q.bitCnt == `CCP_ACK_BIT) begin
					d.bitCnt = 4'h0;
					d.sdaLow = 1'b0;
					unique case (q.st)
						I2C_ADDR: begin
							if (q.rdWr) begin
								d.st = I2C_RDATA;
								d.shReg = regRdData;
								d.sdaLow = ~regRdData[7];
							end else begin
								d.st = I2C_PTR;
							end
						end
						I2C_PTR: d.st = I2C_WDATA;
						I2C_WDATA: d.ptr = q.ptr + 7'h01;
						I2C_RDATA: begin
							if (q.acked) begin
								d.shReg = regRdData;
								d.sdaLow = ~regRdData[7];
							end else begin
								d.st = I2C_SKIP;
							end
						end
						I2C_IDLE, I2C_SKIP: d.st = q.st;
					endcase
				end else if (q.st == I2C_RDATA && q.bitCnt != 4'h0) begin
					d.shReg = {q.shReg[6:0], 1'b0};
					d.sdaLow = ~q.shReg[6];
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			q <= CORE_RST;
		end else begin
			q <= d;
		end
	end

	assign sdaOut = 1'b0;
	assign sdaOe = q.sdaLow;

	// Slave-out pin
	assign misoOut = misoBitQ;
	assign misoOe = misoOeQ;

	// Register file side; read address follows the active protocol
	assign regRdAddr = spiMode ? spiQ.cmd[7:1] : q.ptr;
	assign regWrEn = q.wrEn;
	assign regWrAddr = q.wrAddr;
	assign regWrData = q.wrData;

endmodule

// *** bench/ccp_control_port_properties.sv ***
`timescale 1ns/100ps
// Pin-level watcher for the control port
module ccp_props (
	// Clock, reset, strap
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic spiSelect,
	input wire logic gcEnable,
	// Two-wire pins
	input wire logic sclIn,
	input wire logic sdaIn,
	input wire logic sdaOut,
	input wire logic sdaOe,
	// Four-wire pins
	input wire logic spiSclk,
	input wire logic portSelectN,
	input wire logic mosi,
	input wire logic misoOut,
	input wire logic misoOe,
	// Register side
	input wire logic [6:0] regRdAddr,
	input wire logic [7:0] regRdData,
	input wire logic regWrEn,
	input wire logic [6:0] regWrAddr,
	input wire logic [7:0] regWrData
);
	// Slave-out is sampled on the system clock too, as it is fast enough
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);

	AST_SDA_LOW_ONLY: assert property (sdaOut == 1'b0)
		else $error("data line driven high");
	AST_SDA_AT_LOW: assert property ($changed(sdaOe) |-> !$past(sclIn, 3))
		else $error("data line moved while clock high");
	AST_TWO_WIRE_OFF: assert property (spiSelect && $past(spiSelect, 4)
		|-> !sdaOe)
		else $error("two-wire answer in four-wire mode");
	AST_MISO_RELEASED: assert property (portSelectN && $past(portSelectN)
		|-> !misoOe)
		else $error("slave-out driven while deselected");
	AST_MISO_ON_RISE: assert property ($changed(misoOut)
		|-> spiSclk || portSelectN)
		else $error("slave-out moved away from rising edge");
	AST_WR_ONE_CYCLE: assert property (regWrEn |=> !regWrEn)
		else $error("write strobe too long");
	AST_WR_HOLD: assert property (!regWrEn
		|-> $stable(regWrAddr) && $stable(regWrData))
		else $error("write address or data moved without strobe");
	AST_WR_ACKED: assert property (regWrEn && !spiSelect |-> sdaOe)
		else $error("two-wire write without acknowledge");
	AST_WR_AT_PTR: assert property (regWrEn && !spiSelect
		|-> regWrAddr == regRdAddr)
		else $error("two-wire write away from pointer");

	// Main traffic kinds
	cover property (regWrEn && !spiSelect);
	cover property (regWrEn && spiSelect);
	cover property ($rose(misoOe));
endmodule

bind ccp_control_port ccp_props i_props (
	.mclk(mclk), .rst_n(rst_n), .spiSelect(spiSelect), .gcEnable(gcEnable),
	.sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
	.spiSclk(spiSclk), .portSelectN(portSelectN), .mosi(mosi),
	.misoOut(misoOut), .misoOe(misoOe), .regRdAddr(regRdAddr),
	.regRdData(regRdData), .regWrEn(regWrEn), .regWrAddr(regWrAddr),
	.regWrData(regWrData)
);

// *** bench/ccp_host.sv ***
`timescale 1ns/100ps
// Host master for both links
module ccp_host (
	// Paces the two-wire bus
	input wire logic mclk,
	// Two-wire bus
	output logic sclIn,
	output wire logic sdaIn,
	input wire logic sdaOe,
	// Four-wire port
	output logic spiSclk,
	output logic portSelectN,
	output logic mosi,
	input wire logic misoOut,
	input wire logic misoOe
);
	logic pullLow = 1'b0;
	int half = 8;
	// pull-up wins unless someone pulls low
	assign sdaIn = !(sdaOe || pullLow);
	// Idle levels; serial clock stands still outside frames
	initial begin
		sclIn = 1'b1;
		spiSclk = 1'b0;
		portSelectN = 1'b1;
		mosi = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// start, also usable as repeated start
	task automatic start();
		pullLow <= 1'b0;
		tick(half);
		sclIn <= 1'b1;
		tick(half);
		pullLow <= 1'b1;
		tick(half);
		sclIn <= 1'b0;
		tick(2);
	endtask
	task automatic stop();
		pullLow <= 1'b1;
		tick(half);
		sclIn <= 1'b1;
		tick(half);
		pullLow <= 1'b0;
		tick(half);
	endtask
	// data set while clock low, read while high
	task automatic clk(input logic b, output logic r);
		pullLow <= !b;
		tick(half);
		sclIn <= 1'b1;
		tick(half);
		r = sdaIn;
		sclIn <= 1'b0;
		tick(2);
	endtask
	// eight bits MSB first, then acknowledge slot
	task automatic xfer(input logic [7:0] tx, input logic ackOut,
		output logic [7:0] rx, output logic ack);
		for (int i = 7; i >= 0; i--)
			clk(tx[i], rx[i]);
		clk(ackOut, ack);
	endtask
	// fresh select edge, master drives on rising edge
	task automatic frame(input logic [15:0] tx, output logic [15:0] rx);
		portSelectN = 1'b0;
		// Odd lead-in keeps serial clock edges off the system clock edges
		#21.3;
		for (int i = 15; i >= 0; i--) begin
			spiSclk = 1'b1;
			mosi = tx[i];
			#7.5;
			spiSclk = 1'b0;
			// Released slave-out reads as a toggling pattern
			rx[i] = misoOe ? misoOut : i[0];
			#7.5;
		end
		#20;
		portSelectN = 1'b1;
		mosi = !mosi;
	endtask
endmodule

// *** bench/tb_ccp_control_port.sv ***
`timescale 1ns/100ps
// Control port against the host model and a small register file
module tb_ccp_control_port;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic spiSelect = 1'b0;
	logic gcEnable = 1'b0;
	logic sclIn, sdaIn, sdaOut, sdaOe, spiSclk, portSelectN, mosi;
	logic misoOut, misoOe, regWrEn, ack;
	logic [6:0] regRdAddr, regWrAddr;
	logic [7:0] regWrData, rx;
	logic [15:0] srx;
	logic [7:0] mem [128];
	int fails = 0;
	int testsRun = 0;

	always #2.5 mclk = !mclk;
	// Register file, read without delay
	always_ff @(posedge mclk)
		if (regWrEn)
			mem[regWrAddr] <= regWrData;

	ccp_control_port i_dut (.mclk(mclk), .rst_n(rst_n),
		.spiSelect(spiSelect), .gcEnable(gcEnable), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .spiSclk(spiSclk),
		.portSelectN(portSelectN), .mosi(mosi), .misoOut(misoOut),
		.misoOe(misoOe), .regRdAddr(regRdAddr),
		.regRdData(mem[regRdAddr]), .regWrEn(regWrEn),
		.regWrAddr(regWrAddr), .regWrData(regWrData));
	ccp_host i_host (.mclk(mclk), .sclIn(sclIn), .sdaIn(sdaIn),
		.sdaOe(sdaOe), .spiSclk(spiSclk), .portSelectN(portSelectN),
		.mosi(mosi), .misoOut(misoOut), .misoOe(misoOe));

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		testsRun++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// Byte to the device that must be acknowledged
	task automatic put(input logic [7:0] b);
		i_host.xfer(b, 1'b1, rx, ack);
		check({7'h00, ack}, 8'h00);
	endtask
	task automatic results();
		$display("checks %0d, wrong %0d", testsRun, fails);
		if (fails == 0 && testsRun > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		// Pointer, then two data bytes by auto-increment
		i_host.start();
		put(8'h30);
		put(8'h05);
		put(8'hA5);
		put(8'h3C);
		i_host.stop();
		check(mem[5], 8'hA5);
		check(mem[6], 8'h3C);
		// Pointer, repeated start, two reads
		i_host.start();
		put(8'h30);
		put(8'h05);
		i_host.start();
		put(8'h31);
		i_host.xfer(8'hFF, 1'b0, rx, ack);
		check(rx, 8'hA5);
		i_host.xfer(8'hFF, 1'b1, rx, ack);
		check(rx, 8'h3C);
		i_host.stop();
		// Foreign address, general call disabled, then enabled
		for (int i = 0; i < 3; i++) begin
			gcEnable <= (i == 2);
			i_host.start();
			i_host.xfer(i == 0 ? 8'h32 : 8'h00, 1'b1, rx, ack);
			i_host.stop();
			check({7'h00, ack}, {7'h00, i != 2});
		end
		// Four-wire write, then read of the same register
		// whole register value written
		spiSelect <= 1'b1;
		repeat (4) @(posedge mclk);
		i_host.frame(16'h205A, srx);
		repeat (8) @(posedge mclk);
		check(mem[16], 8'h5A);
		check(srx[15:8], 8'hAA);
		check(srx[7:0], 8'hAA);
		i_host.frame(16'h2100, srx);
		repeat (8) @(posedge mclk);
		check(srx[7:0], 8'h5A);
		check(mem[16], 8'h5A);
		check({7'h00, misoOe}, 8'h00);
		results();
	end
	// Hang guard, well beyond the expected run
	initial begin
		#200000;
		fails++;
		results();
	end
endmodule
